// ===== core/drive_cfg_pkg.sv
// Functional notes
// - Writing the exact reboot key word to the reboot command register starts a restart; any other value does not.
// - The restart is held off by the reboot delay in milliseconds, counted from acceptance of the key.
// - While the boot loader runs, windings are shorted when the boot config bit is 0 and left open when it is 1.
// - Submode bit 0 selects open loop when cleared and closed loop when set.
// - The loop select bit cannot change while operation is enabled; the host toggles it only outside that state.
// - The ramp speed emulation bit makes speed modes run as S-ramp position steps instead of a velocity loop.
// - Submode bit 2 hands holding brake engage and release to the device.
// - The current reduce bit applies reduced motor current in open loop.
// - With closed loop and startup alignment set, alignment runs in open loop after power-up, then goes closed loop.
// - With startup alignment clear, the drive stays open loop until the encoder index is seen.
// - An encoder configured without index forces startup alignment regardless of the alignment bit.
// - In torque modes bit 5 runs only the torque controller; clear, a velocity controller is superimposed.
// - Submode bit 6 marks the motor as brushless DC.
// - The creep speed bit enables low-speed mode; the host must enable closed loop first.
// - Feedback selection writes during operation enabled go to a shadow and apply on the next entry to that state.
package drive_cfg_pkg;
	// the submode index is not word aligned, so its word sits at four times the index
	localparam logic [15:0] IDX_SUBMODE = 16'h3202;
	localparam logic [15:0] ADDR_SUBMODE = {IDX_SUBMODE[13:0], 2'b00};
	localparam logic [15:0] ADDR_ENTRY_COUNT = 16'h2800;
	localparam logic [15:0] ADDR_REBOOT_KEY = 16'h2804;
	localparam logic [15:0] ADDR_REBOOT_DELAY = 16'h2808;
	localparam logic [15:0] ADDR_BOOT_CFG = 16'h280C;
	localparam logic [15:0] ADDR_FB_SEL = 16'h3204;
	localparam logic [15:0] ADDR_STATUS = 16'h3208;
	localparam logic [31:0] REBOOT_KEY_WORD = 32'h746F6F62;
	localparam logic [7:0] ENTRY_COUNT = 8'h03;
	localparam logic [31:0] SUBMODE_RESET = 32'h00000000;
	localparam logic [7:0] SUBMODE_MASK = 8'hFF;
	localparam logic [31:0] KEY_RESET = 32'h00000000;
	localparam logic [31:0] DELAY_RESET = 32'h00000000;
	localparam logic [31:0] BOOT_CFG_RESET = 32'h00000000;
	localparam logic [23:0] FB_SEL_RESET = 24'h000000;
	localparam int BIT_LOOP = 0;
	localparam int BIT_RAMP = 1;
	localparam int BIT_BRAKE = 2;
	localparam int BIT_CURRENT_REDUCE = 3;
	localparam int BIT_ALIGN = 4;
	localparam int BIT_TORQUE = 5;
	localparam int BIT_BLDC = 6;
	localparam int BIT_CREEP = 7;
	localparam int CLK_HZ = 25000000;
	localparam int MS_PER_S = 1000;
	localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
	typedef struct packed {
		logic loop_select;
		logic ramp_speed_emulation;
		logic auto_brake;
		logic current_reduce;
		logic startup_alignment;
		logic torque_only;
		logic bldc_motor;
		logic creep_speed;
	} submode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_FIRE = 2'b10
	} reboot_state_t;
	typedef enum logic [1:0] {
		CM_OPEN = 2'b00,
		CM_ALIGN = 2'b01,
		CM_INDEX = 2'b10,
		CM_CLOSED = 2'b11
	} comm_state_t;
endpackage

// ===== core/ms_tick.sv
`timescale 1ns/1ps
`default_nettype none
// divider giving one-cycle pulses per millisecond
module ms_tick
	import drive_cfg_pkg::*;
#(
	parameter int DIV = CYCLES_PER_MS
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic clear_i,
	output logic tick_o
);
	initial begin
		if (DIV < 1) $error("ms_tick: DIV must be at least 1");
	end
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic next_tick;
	// restartable so the first millisecond is whole after key acceptance
	always_comb begin
		next_cnt = cnt + 32'h00000001;
		next_tick = 1'b0;
		if (clear_i) begin
			next_cnt = 32'h00000000;
		end else if (cnt >= 32'(DIV - 1)) begin
			next_cnt = 32'h00000000;
			next_tick = 1'b1;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			cnt <= 32'h00000000;
			tick_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick_o <= next_tick;
		end
	end
endmodule
`default_nettype wire

// ===== core/drive_mode_and_reboot_regs.sv
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module drive_mode_and_reboot_regs
	import drive_cfg_pkg::*;
#(
	parameter int MS_DIV = CYCLES_PER_MS
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [15:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic op_enabled_i,
	input wire logic bootloader_active_i,
	input wire logic encoder_no_index_i,
	input wire logic index_seen_i,
	input wire logic align_done_i,
	input wire logic power_up_i,
	input wire logic torque_mode_i,
	output logic reboot_o,
	output logic winding_short_o,
	output logic closed_loop_o,
	output logic align_run_o,
	output logic ramp_emulation_o,
	output logic auto_brake_o,
	output logic reduced_current_o,
	output logic torque_only_o,
	output logic velocity_superimpose_o,
	output logic bldc_o,
	output logic creep_o,
	output logic [23:0] fb_sel_o
);
	initial begin
		if (MS_DIV < 1) $error("MS_DIV must be at least 1");
	end

	// synchronisers for the pin-level inputs
	logic [1:0] s_op, s_boot, s_noidx, s_idx, s_aldone, s_pwr, s_trq;
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			s_op <= 2'b00;
			s_boot <= 2'b00;
			s_noidx <= 2'b00;
			s_idx <= 2'b00;
			s_aldone <= 2'b00;
			s_pwr <= 2'b00;
			s_trq <= 2'b00;
		end else begin
			s_op <= {s_op[0], op_enabled_i};
			s_boot <= {s_boot[0], bootloader_active_i};
			s_noidx <= {s_noidx[0], encoder_no_index_i};
			s_idx <= {s_idx[0], index_seen_i};
			s_aldone <= {s_aldone[0], align_done_i};
			s_pwr <= {s_pwr[0], power_up_i};
			s_trq <= {s_trq[0], torque_mode_i};
		end
	end
	logic op_en, boot_on, no_idx, idx_seen, al_done, pwr_up, trq_mode;
	assign op_en = s_op[1];
	assign boot_on = s_boot[1];
	assign no_idx = s_noidx[1];
	assign idx_seen = s_idx[1];
	assign al_done = s_aldone[1];
	assign pwr_up = s_pwr[1];
	assign trq_mode = s_trq[1];

	// apb: setup cycle then an access cycle answered after one wait state
	logic wr_acc, rd_acc;
	assign wr_acc = psel_i && penable_i && pwrite_i && !pready_o;
	assign rd_acc = psel_i && penable_i && !pwrite_i && !pready_o;
	logic addr_ok;
	always_comb begin
		unique case (paddr_i)
			ADDR_SUBMODE, ADDR_ENTRY_COUNT, ADDR_REBOOT_KEY,
			ADDR_REBOOT_DELAY, ADDR_BOOT_CFG, ADDR_FB_SEL, ADDR_STATUS: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end

	// register file state
	logic [7:0] submode, next_submode;
	logic [31:0] key_reg, next_key_reg;
	logic [31:0] delay_reg, next_delay_reg;
	logic [31:0] boot_cfg, next_boot_cfg;
	logic [23:0] fb_shadow, next_fb_shadow;
	logic [23:0] fb_active, next_fb_active;
	logic op_en_d;
	logic key_hit;
	logic op_entry;
	assign op_entry = op_en && !op_en_d;
	always_comb begin
		next_submode = submode;
		next_key_reg = key_reg;
		next_delay_reg = delay_reg;
		next_boot_cfg = boot_cfg;
		next_fb_shadow = fb_shadow;
		next_fb_active = fb_active;
		key_hit = 1'b0;
		if (wr_acc) begin
			unique case (paddr_i)
				ADDR_SUBMODE: begin
					next_submode = pwdata_i[7:0] & SUBMODE_MASK;
					// loop select frozen during operation enabled
					if (op_en) begin
						next_submode[BIT_LOOP] = submode[BIT_LOOP];
					end
					// creep needs loop select set in the resulting word; refused otherwise
					if (!next_submode[BIT_LOOP]) begin
						next_submode[BIT_CREEP] = 1'b0;
					end
				end
				ADDR_REBOOT_KEY: begin
					next_key_reg = pwdata_i;
					key_hit = (pwdata_i == REBOOT_KEY_WORD);
				end
				ADDR_REBOOT_DELAY: next_delay_reg = pwdata_i;
				ADDR_BOOT_CFG: next_boot_cfg = pwdata_i;
				ADDR_FB_SEL: begin
					next_fb_shadow = pwdata_i[23:0];
					// outside operation enabled the selection applies at once
					if (!op_en) begin
						next_fb_active = pwdata_i[23:0];
					end
				end
				default: begin
				end
			endcase
		end
		// buffered selection is picked up on entry to operation enabled
		if (op_entry) begin
			next_fb_active = next_fb_shadow;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			submode <= SUBMODE_RESET[7:0];
			key_reg <= KEY_RESET;
			delay_reg <= DELAY_RESET;
			boot_cfg <= BOOT_CFG_RESET;
			fb_shadow <= FB_SEL_RESET;
			fb_active <= FB_SEL_RESET;
			op_en_d <= 1'b0;
		end else begin
			submode <= next_submode;
			key_reg <= next_key_reg;
			delay_reg <= next_delay_reg;
			boot_cfg <= next_boot_cfg;
			fb_shadow <= next_fb_shadow;
			fb_active <= next_fb_active;
			op_en_d <= op_en;
		end
	end

	// reboot delay sequencer
	reboot_state_t rb_state, next_rb_state;
	logic [31:0] ms_left, next_ms_left;
	logic ms_pulse;
	logic next_reboot;
	ms_tick #(
		.DIV(MS_DIV)
	) u_ms_tick (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.clear_i(key_hit),
		.tick_o(ms_pulse)
	);
	// a repeated key while waiting restarts the delay from the new acceptance
	always_comb begin
		next_rb_state = rb_state;
		next_ms_left = ms_left;
		next_reboot = 1'b0;
		unique case (rb_state)
			ST_IDLE: begin
				if (key_hit) begin
					next_ms_left = next_delay_reg;
					next_rb_state = (next_delay_reg == 32'h00000000) ? ST_FIRE : ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (key_hit) begin
					next_ms_left = next_delay_reg;
				end else if (ms_pulse) begin
					if (ms_left <= 32'h00000001) begin
						next_rb_state = ST_FIRE;
					end
					next_ms_left = ms_left - 32'h00000001;
				end
			end
			ST_FIRE: begin
				next_reboot = 1'b1;
				next_rb_state = ST_IDLE;
			end
			default: next_rb_state = ST_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rb_state <= ST_IDLE;
			ms_left <= 32'h00000000;
		end else begin
			rb_state <= next_rb_state;
			ms_left <= next_ms_left;
		end
	end

	// commutation start-up sequence
	comm_state_t cm_state, next_cm_state;
	logic need_align;
	assign need_align = submode[BIT_ALIGN] || no_idx;
	always_comb begin
		next_cm_state = cm_state;
		unique case (cm_state)
			CM_OPEN: begin
				if (submode[BIT_LOOP]) begin
					next_cm_state = need_align ? CM_ALIGN : CM_INDEX;
				end
			end
			CM_ALIGN: begin
				if (!submode[BIT_LOOP]) begin
					next_cm_state = CM_OPEN;
				end else if (al_done) begin
					next_cm_state = CM_CLOSED;
				end
			end
			CM_INDEX: begin
				if (!submode[BIT_LOOP]) begin
					next_cm_state = CM_OPEN;
				end else if (need_align) begin
					next_cm_state = CM_ALIGN;
				end else if (idx_seen) begin
					next_cm_state = CM_CLOSED;
				end
			end
			CM_CLOSED: begin
				if (!submode[BIT_LOOP]) begin
					next_cm_state = CM_OPEN;
				end
			end
		endcase
		// power-up restarts the search so alignment, or index search when no alignment is needed, reruns after switch-on
		if (pwr_up) begin
			next_cm_state = CM_OPEN;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			cm_state <= CM_OPEN;
		end else begin
			cm_state <= next_cm_state;
		end
	end

	// registered outputs and apb read path
	logic [31:0] next_prdata;
	logic next_slverr;
	logic next_ready;
	always_comb begin
		next_prdata = 32'h00000000;
		unique case (paddr_i)
			ADDR_SUBMODE: next_prdata = {24'h000000, submode};
			ADDR_ENTRY_COUNT: next_prdata = {24'h000000, ENTRY_COUNT};
			ADDR_REBOOT_KEY: next_prdata = key_reg;
			ADDR_REBOOT_DELAY: next_prdata = delay_reg;
			ADDR_BOOT_CFG: next_prdata = boot_cfg;
			ADDR_FB_SEL: next_prdata = {8'h00, fb_shadow};
			ADDR_STATUS: next_prdata = {24'h000000, fb_active[0], op_en, rb_state, 2'b00, cm_state};
			default: next_prdata = 32'h00000000;
		endcase
		if (!rd_acc) begin
			next_prdata = 32'h00000000;
		end
		next_ready = psel_i && penable_i && !pready_o;
		next_slverr = next_ready && (!addr_ok || (pwrite_i && (paddr_i == ADDR_ENTRY_COUNT || paddr_i == ADDR_STATUS)));
	end
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			reboot_o <= 1'b0;
			winding_short_o <= 1'b0;
			closed_loop_o <= 1'b0;
			align_run_o <= 1'b0;
			ramp_emulation_o <= 1'b0;
			auto_brake_o <= 1'b0;
			reduced_current_o <= 1'b0;
			torque_only_o <= 1'b0;
			velocity_superimpose_o <= 1'b0;
			bldc_o <= 1'b0;
			creep_o <= 1'b0;
			fb_sel_o <= FB_SEL_RESET;
		end else begin
			prdata_o <= next_prdata;
			pready_o <= next_ready;
			pslverr_o <= next_slverr;
			reboot_o <= next_reboot;
			winding_short_o <= boot_on && !boot_cfg[0];
			closed_loop_o <= (cm_state == CM_CLOSED);
			align_run_o <= (cm_state == CM_ALIGN);
			ramp_emulation_o <= submode[BIT_RAMP];
			auto_brake_o <= submode[BIT_BRAKE];
			reduced_current_o <= submode[BIT_CURRENT_REDUCE] && (cm_state != CM_CLOSED);
			torque_only_o <= trq_mode && submode[BIT_TORQUE];
			velocity_superimpose_o <= trq_mode && !submode[BIT_TORQUE];
			bldc_o <= submode[BIT_BLDC];
			creep_o <= submode[BIT_CREEP] && submode[BIT_LOOP];
			fb_sel_o <= fb_active;
		end
	end
endmodule
`default_nettype wire

// ===== bench/drive_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the register block, bus timing first, then outputs
module drive_regs_assertions
	import drive_cfg_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [15:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic reboot_o,
	input wire logic closed_loop_o,
	input wire logic align_run_o,
	input wire logic torque_only_o,
	input wire logic velocity_superimpose_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);
	// an access phase that has not been answered yet
	sequence s_take;
		psel_i && penable_i && !pready_o;
	endsequence
	sequence s_read(a);
		s_take ##0 (!pwrite_i && paddr_i == a);
	endsequence
	a_one_wait: assert property (s_take |=> pready_o) else $error("access not answered after one wait");
	a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
	a_idle_data: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data outside answer");
	a_count_read: assert property (s_read(ADDR_ENTRY_COUNT) |=> prdata_o == {24'h0, ENTRY_COUNT})
		else $error("entry count wrong");
	a_high_zero: assert property (s_read(ADDR_SUBMODE) |=> prdata_o[31:8] == 24'h0)
		else $error("upper submode bits not zero");
	a_reboot_pulse: assert property (reboot_o |=> !reboot_o) else $error("reboot pulse too long");
	a_torque_split: assert property (!(torque_only_o && velocity_superimpose_o))
		else $error("torque only and velocity together");
	a_align_open: assert property (align_run_o |-> !closed_loop_o) else $error("alignment in closed loop");
endmodule
bind drive_mode_and_reboot_regs drive_regs_assertions u_chk (.clk_sys_i, .srst_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .reboot_o, .closed_loop_o, .align_run_o,
	.torque_only_o, .velocity_superimpose_o);
`default_nettype wire

// ===== bench/host_cfg_model.sv
`timescale 1ns/1ps
`default_nettype none
// configuration host: an APB master that the bench drives through xfer
module host_cfg_model (
	input wire logic clk_i,
	input wire logic pready_i,
	input wire logic pslverr_i,
	input wire logic [31:0] prdata_i,
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [15:0] paddr_o,
	output logic [31:0] pwdata_o
);
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 16'h0000;
		pwdata_o = 32'h00000000;
	end
	// request held until pready is seen at an edge; bounded so a dead slave cannot hang
	task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e, output bit ok);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= w;
		paddr_o <= a;
		pwdata_o <= d;
		@(posedge clk_i);
		penable_o <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_i !== 1'b1 && n < 50);
		ok = (pready_i === 1'b1);
		r = prdata_i;
		e = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		pwdata_o <= ~d; // released data must not look held
	endtask
endmodule
`default_nettype wire

// ===== bench/drive_mode_and_reboot_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module drive_mode_and_reboot_regs_test;
	import drive_cfg_pkg::*;
	localparam int DIV = 4;
	logic clk_sys_i, srst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
	logic [15:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic op_enabled_i, bootloader_active_i, encoder_no_index_i, index_seen_i, align_done_i, power_up_i;
	logic torque_mode_i, reboot_o, winding_short_o, closed_loop_o, align_run_o, ramp_emulation_o;
	logic auto_brake_o, reduced_current_o, torque_only_o, velocity_superimpose_o, bldc_o, creep_o;
	logic [23:0] fb_sel_o;
	int failures, samples_checked;
	drive_mode_and_reboot_regs #(.MS_DIV(DIV)) DUT (.clk_sys_i, .srst_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .op_enabled_i, .bootloader_active_i,
		.encoder_no_index_i, .index_seen_i, .align_done_i, .power_up_i, .torque_mode_i, .reboot_o,
		.winding_short_o, .closed_loop_o, .align_run_o, .ramp_emulation_o, .auto_brake_o, .reduced_current_o,
		.torque_only_o, .velocity_superimpose_o, .bldc_o, .creep_o, .fb_sel_o);
	host_cfg_model HOST (.clk_i(clk_sys_i), .pready_i(pready_o), .pslverr_i(pslverr_o), .prdata_i(prdata_o),
		.psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i), .pwdata_o(pwdata_i));
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_pin(input string n, input logic e, input logic g);
		chk(n, {31'h0, e}, {31'h0, g});
	endtask
	// one bus access; a slave that never answers ends the run
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic ee,
		output logic [31:0] r);
		logic e;
		bit ok;
		HOST.xfer(w, a, d, r, e, ok);
		if (!ok) begin
			failures++;
			finish_test();
		end else begin
			chk_pin("pslverr", ee, e);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] r;
		acc(1'b1, a, d, ee, r);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic ee);
		logic [31:0] r;
		acc(1'b0, a, 32'h0, ee, r);
		chk("rdata", x, r);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	// creep is dropped when loop select ends up clear, upper bits read zero
	function automatic logic [31:0] exp_sub(input logic [31:0] v);
		return {24'h0, v[7] & v[0], v[6:0]};
	endfunction
	initial begin
		logic [31:0] v;
		int n;
		int lo;
		srst_i = 1'b1;
		{op_enabled_i, bootloader_active_i, encoder_no_index_i, index_seen_i} = 4'h0;
		{align_done_i, power_up_i, torque_mode_i} = 3'h0;
		void'($urandom(4481));
		wt(20);
		srst_i <= 1'b0;
		wt(2);
		rd(ADDR_SUBMODE, SUBMODE_RESET, 1'b0);
		rd(ADDR_ENTRY_COUNT, {24'h0, ENTRY_COUNT}, 1'b0);
		rd(ADDR_REBOOT_KEY, KEY_RESET, 1'b0);
		rd(ADDR_REBOOT_DELAY, DELAY_RESET, 1'b0);
		rd(ADDR_BOOT_CFG, BOOT_CFG_RESET, 1'b0);
		wr(ADDR_ENTRY_COUNT, 32'h000000FF, 1'b1);
		wr(ADDR_STATUS, 32'h000000FF, 1'b1);
		rd(ADDR_ENTRY_COUNT, {24'h0, ENTRY_COUNT}, 1'b0);
		rd(16'h1000, 32'h0, 1'b1);
		// corner words first, then random submode words with random torque mode
		for (int i = 0; i < 12; i++) begin
			v = (i == 0) ? 32'h00000080 : (i == 1) ? 32'hFFFFFFFF : $urandom;
			torque_mode_i <= 1'($urandom);
			wr(ADDR_SUBMODE, v, 1'b0);
			rd(ADDR_SUBMODE, exp_sub(v), 1'b0);
			wt(4);
			chk_pin("ramp", v[1], ramp_emulation_o);
			chk_pin("brake", v[2], auto_brake_o);
			chk_pin("redcur", v[3], reduced_current_o);
			chk_pin("bldc", v[6], bldc_o);
			chk_pin("creep", v[7] & v[0], creep_o);
			chk_pin("tq_only", torque_mode_i & v[5], torque_only_o);
			chk_pin("vel_sup", torque_mode_i & ~v[5], velocity_superimpose_o);
			chk_pin("closed", 1'b0, closed_loop_o);
		end
		// loop select frozen while operation is enabled
		wr(ADDR_SUBMODE, 32'h0, 1'b0);
		op_enabled_i <= 1'b1;
		wt(4);
		wr(ADDR_SUBMODE, 32'h00000001, 1'b0);
		rd(ADDR_SUBMODE, 32'h0, 1'b0);
		op_enabled_i <= 1'b0;
		wt(4);
		// commutation: alignment, index search, forced alignment, power-up
		wr(ADDR_SUBMODE, 32'h00000011, 1'b0);
		wt(4);
		chk_pin("align", 1'b1, align_run_o);
		align_done_i <= 1'b1;
		wt(5);
		chk_pin("closed", 1'b1, closed_loop_o);
		align_done_i <= 1'b0;
		wr(ADDR_SUBMODE, 32'h0, 1'b0);
		wt(4);
		chk_pin("closed", 1'b0, closed_loop_o);
		wr(ADDR_SUBMODE, 32'h00000001, 1'b0);
		wt(4);
		chk_pin("align", 1'b0, align_run_o);
		index_seen_i <= 1'b1;
		wt(5);
		chk_pin("closed", 1'b1, closed_loop_o);
		// reduction is asked for but the loop is closed, so it must stay off
		wr(ADDR_SUBMODE, 32'h00000009, 1'b0);
		wt(2);
		chk_pin("redcur", 1'b0, reduced_current_o);
		index_seen_i <= 1'b0;
		wr(ADDR_SUBMODE, 32'h0, 1'b0);
		encoder_no_index_i <= 1'b1;
		wr(ADDR_SUBMODE, 32'h00000001, 1'b0);
		wt(5);
		chk_pin("align", 1'b1, align_run_o);
		power_up_i <= 1'b1;
		wt(5);
		chk_pin("align", 1'b0, align_run_o);
		power_up_i <= 1'b0;
		encoder_no_index_i <= 1'b0;
		// winding short only while the boot loader runs and the flag is clear
		bootloader_active_i <= 1'b1;
		wt(5);
		chk_pin("short", 1'b1, winding_short_o);
		wr(ADDR_BOOT_CFG, 32'h00000001, 1'b0);
		wt(2);
		chk_pin("short", 1'b0, winding_short_o);
		bootloader_active_i <= 1'b0;
		// feedback selection shadowed during operation enabled
		wr(ADDR_FB_SEL, 32'h00030201, 1'b0);
		wt(2);
		chk("fb", 32'h00030201, {8'h0, fb_sel_o});
		op_enabled_i <= 1'b1;
		wt(4);
		wr(ADDR_FB_SEL, 32'h00070605, 1'b0);
		op_enabled_i <= 1'b0;
		wt(4);
		chk("fb", 32'h00030201, {8'h0, fb_sel_o});
		op_enabled_i <= 1'b1;
		wt(5);
		chk("fb", 32'h00070605, {8'h0, fb_sel_o});
		op_enabled_i <= 1'b0;
		// a near-miss key and an unrelated key must stay quiet; the true key fires after the delay
		for (int k = 0; k < 2; k++) begin
			wr(ADDR_REBOOT_KEY, k ? 32'h12345678 : 32'h746F6F63, 1'b0);
			n = 0;
			repeat (30) begin
				@(posedge clk_sys_i);
				n += int'(reboot_o === 1'b1);
			end
			chk("no_reboot", 32'h0, n);
		end
		for (int d = 0; d < 3; d += 2) begin
			wr(ADDR_REBOOT_DELAY, d, 1'b0);
			wr(ADDR_REBOOT_KEY, REBOOT_KEY_WORD, 1'b0);
			n = 0;
			lo = d * DIV;
			while (reboot_o !== 1'b1 && n < 100) begin
				@(posedge clk_sys_i);
				n++;
			end
			chk_pin("reboot_time", 1'b1, reboot_o === 1'b1 && n >= lo && n <= lo + DIV + 3);
		end
		finish_test();
	end
endmodule
`default_nettype wire
